// >>> rtl/sstcfg_pkg.sv
// Package with register map, field layout and timing constants.
package sstcfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FIFO_WATERMARK_LEVEL = 8'h31;
  localparam logic [7:0] ADDR_SELFTEST_STEP_CONFIG = 8'h32;
  localparam logic [7:0] ADDR_STEP_VALLEY_VALUE = 8'h34;
  localparam logic [7:0] RST_FIFO_WATERMARK_LEVEL = 8'h00;
  localparam logic [7:0] RST_SELFTEST_STEP_CONFIG = 8'h00;
  localparam logic [7:0] RST_STEP_VALLEY_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int POS_SELFTEST_EN = 7;
  localparam int POS_AMP_PEAK = 5;
  localparam int POS_SINGLE_AXIS = 3;
  localparam int POS_SIGN = 2;
  localparam logic [7:0] MASK_WATERMARK = 8'h3f;
  localparam logic [7:0] MASK_VALLEY = 8'h3f;
  localparam logic [7:0] MASK_CONFIG = 8'hbf;

  // ----------------------------------------------------------------
  // Axis codes and threshold arithmetic
  // ----------------------------------------------------------------
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [1:0] AXIS_Y = 2'h1;
  // Threshold in units of 0.01 mg: code * 391 + 10000 (0.1 g).
  localparam logic [15:0] FBZ_STEP_CMG = 16'h0187;
  localparam logic [19:0] FBZ_OFFSET_CMG = 20'h02710;
  localparam int SELFTEST_SETTLE_MS = 3;
  localparam int CLK_MHZ = 200;
  localparam int SELFTEST_SETTLE_CYC = SELFTEST_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic x;
    logic y;
    logic z;
  } sstcfg_axis_type;

  typedef struct packed {
    logic selftest_on;
    logic amp_high;
    logic sign_pos;
    sstcfg_axis_type axis;
  } sstcfg_selftest_type;

  typedef struct packed {
    logic peak_valley_match;
    logic single_axis;
    sstcfg_axis_type axis;
    logic [5:0] valley;
  } sstcfg_step_type;

endpackage

// >>> rtl/sstcfg_fifo_count.sv
// FIFO frame counter and watermark comparator.
`timescale 1ns/1ps
module sstcfg_fifo_count (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Frame traffic
  input wire logic frame_wr,
  input wire logic frame_rd,
  input wire logic clear,
  input wire logic [5:0] level,
  // Status
  output logic [5:0] frame_count,
  output logic watermark_hit
);
  import sstcfg_pkg::*;

  logic [5:0] count_ff;
  logic [5:0] nxt_count;
  logic hit_ff;

  always_comb begin
    nxt_count = count_ff;
    if (frame_wr && !frame_rd && count_ff != 6'(FIFO_DEPTH)) begin
      nxt_count = count_ff + 6'h01;
    end else if (frame_rd && !frame_wr && count_ff != 6'h00) begin
      nxt_count = count_ff - 6'h01;
    end
    if (clear) begin
      nxt_count = 6'h00; // R3
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_ff <= 6'h00;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // The compare is refreshed on each stored or read frame; a level change clears it.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clear) begin
      hit_ff <= 1'b0;
    end else if (frame_wr || frame_rd) begin
      hit_ff <= nxt_count > level; // R2 R15
    end
  end

  assign frame_count = count_ff;
  assign watermark_hit = hit_ff;
endmodule

// >>> rtl/sstcfg_regs.sv
// Self-test, step and FIFO watermark configuration register bank.
// ----------------------------------------------------------------
// How it works
// R1 - The front/back z threshold equals code times 3.91 mg plus 0.1 g.
// R2 - The watermark interrupt rises when stored frames exceed the level.
// R3 - A change of the watermark level clears the FIFO frame counter.
// R4 - Config bit 7 set enters self-test, cleared gives normal operation.
// R5 - The host waits at least 3 ms after enabling self-test before use.
// R6 - Config bit 5 is amplitude in self-test, else peak/valley enable.
// R7 - In self-test, bit 5 set gives high amplitude, clear gives low.
// R8 - For the step counter, bit 5 set enables peak and valley matching.
// R9 - Config bit 3 set enables single-axis step counting.
// R10 - The sign bit set gives positive excitation, clear negative.
// R11 - The axis field encodes 00 as x, 01 as y, 10 and 11 as z.
// R12 - In self-test the excitation goes to the selected axis.
// R13 - With step counting on, the same field chooses the step axis.
// R14 - Step on plus single-axis mode counts on the selected axis only.
// R15 - The watermark compare is redone after every frame write.
// R16 - Unused bits of watermark and valley registers read zero.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sstcfg_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Front/back threshold code from its own register
  input wire logic [7:0] front_back_z_threshold,
  output logic [19:0] fbz_threshold_cmg,
  // Step counter enable from the step register
  input wire logic step_enable,
  // FIFO traffic
  input wire logic frame_wr,
  input wire logic frame_rd,
  output logic [5:0] fifo_frame_count,
  output logic fifo_watermark_irq,
  // Self-test and step control outputs
  output sstcfg_pkg::sstcfg_selftest_type selftest_ctl,
  output sstcfg_pkg::sstcfg_step_type step_ctl,
  output logic selftest_settled
);
  import sstcfg_pkg::*;

  logic [7:0] wtmk_ff;
  logic [7:0] conf_ff;
  logic [7:0] valley_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [19:0] fbz_ff;
  sstcfg_selftest_type st_ff;
  sstcfg_step_type step_ff;
  logic [19:0] settle_ff;
  logic settled_ff;
  logic wtmk_change;
  logic wr_wtmk;
  logic wr_conf;
  logic wr_valley;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic sstcfg_axis_type axis_decode(input logic [1:0] code);
    axis_decode.x = (code == AXIS_X); // R11
    axis_decode.y = (code == AXIS_Y);
    axis_decode.z = code[1];
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] w,
                                          input logic [7:0] c,
                                          input logic [7:0] v);
    unique case (addr)
      ADDR_FIFO_WATERMARK_LEVEL: read_mux = w & MASK_WATERMARK; // R16
      ADDR_SELFTEST_STEP_CONFIG: read_mux = c;
      ADDR_STEP_VALLEY_VALUE: read_mux = v & MASK_VALLEY;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Widen before the product: a full code times the step overflows 16 bits.
  function automatic logic [19:0] fbz_scale(input logic [7:0] code);
    fbz_scale = 20'(code) * 20'(FBZ_STEP_CMG) + FBZ_OFFSET_CMG;
  endfunction

  assign wr_wtmk = reg_wr && reg_addr == ADDR_FIFO_WATERMARK_LEVEL;
  assign wr_conf = reg_wr && reg_addr == ADDR_SELFTEST_STEP_CONFIG;
  assign wr_valley = reg_wr && reg_addr == ADDR_STEP_VALLEY_VALUE;
  // Only a real change of the level clears the counter.
  assign wtmk_change =
    wr_wtmk && ((reg_wdata & MASK_WATERMARK) != wtmk_ff); // R3

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wtmk_ff <= RST_FIFO_WATERMARK_LEVEL;
    end else if (wr_wtmk) begin
      wtmk_ff <= reg_wdata & MASK_WATERMARK; // R16
    end
  end

  // Bit 6 has no function and reads zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conf_ff <= RST_SELFTEST_STEP_CONFIG;
    end else if (wr_conf) begin
      conf_ff <= reg_wdata & MASK_CONFIG;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      valley_ff <= RST_STEP_VALLEY_VALUE;
    end else if (wr_valley) begin
      valley_ff <= reg_wdata & MASK_VALLEY; // R16
    end
  end

  // Read data holds until the next read, so the host may fetch it late.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= read_mux(reg_addr, wtmk_ff, conf_ff, valley_ff);
      end
    end
  end

  // ----------------------------------------------------------------
  // Threshold arithmetic
  // ----------------------------------------------------------------
  // Range setting plays no part; only the code and fixed offset count.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fbz_ff <= FBZ_OFFSET_CMG;
    end else begin
      fbz_ff <= fbz_scale(front_back_z_threshold); // R1
    end
  end

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff.selftest_on <= conf_ff[POS_SELFTEST_EN]; // R4
      // The shared bit drives amplitude only while self-test runs.
      st_ff.amp_high <= conf_ff[POS_SELFTEST_EN] &&
                        conf_ff[POS_AMP_PEAK]; // R6 R7
      // The sign follows its bit always; it only matters in self-test.
      st_ff.sign_pos <= conf_ff[POS_SIGN]; // R10
      st_ff.axis <= conf_ff[POS_SELFTEST_EN] ?
                    axis_decode(conf_ff[1:0]) : '0; // R12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      step_ff <= '0;
    end else begin
      step_ff.peak_valley_match <= !conf_ff[POS_SELFTEST_EN] &&
                                   step_enable &&
                                   conf_ff[POS_AMP_PEAK]; // R6 R8
      step_ff.single_axis <= step_enable &&
                             conf_ff[POS_SINGLE_AXIS]; // R9 R14
      step_ff.axis <= step_enable ?
                      axis_decode(conf_ff[1:0]) : '0; // R13 R14
      step_ff.valley <= valley_ff[5:0];
    end
  end

  // Status hint for the host; the host still owns the wait itself.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !conf_ff[POS_SELFTEST_EN]) begin
      settle_ff <= 20'h00000;
      settled_ff <= 1'b0;
    end else if (settle_ff != 20'(SELFTEST_SETTLE_CYC - 1)) begin
      settle_ff <= settle_ff + 20'h00001;
    end else begin
      settled_ff <= 1'b1; // R5
    end
  end

  // ----------------------------------------------------------------
  // FIFO counter
  // ----------------------------------------------------------------
  // Clearing the count wins over a frame stored in the same cycle, so a
  // new level always starts from an empty frame count.
  sstcfg_fifo_count u_count (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .frame_wr(frame_wr),
    .frame_rd(frame_rd),
    .clear(wtmk_change),
    .level(wtmk_ff[5:0]),
    .frame_count(fifo_frame_count),
    .watermark_hit(fifo_watermark_irq)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign fbz_threshold_cmg = fbz_ff;
  assign selftest_ctl = st_ff;
  assign step_ctl = step_ff;
  assign selftest_settled = settled_ff;
endmodule

// >>> tb/sstcfg_regs_chk.sv
// Assertion checker for the self-test, step and watermark register bank.
`timescale 1ns/1ps
module sstcfg_regs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Threshold, step enable and FIFO traffic
  input wire logic [7:0] front_back_z_threshold,
  input wire logic [19:0] fbz_threshold_cmg,
  input wire logic step_enable,
  input wire logic frame_wr,
  input wire logic frame_rd,
  input wire logic [5:0] fifo_frame_count,
  input wire logic fifo_watermark_irq,
  // Decoded controls
  input wire sstcfg_pkg::sstcfg_selftest_type selftest_ctl,
  input wire sstcfg_pkg::sstcfg_step_type step_ctl,
  input wire logic selftest_settled
);
  import sstcfg_pkg::*;
  logic [5:0] lvl_ff;
  logic cfg_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  assign cfg_wr = reg_wr && reg_addr == 8'h32;
  // Shadow level, so a clear can be tied to a real change of value.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) lvl_ff <= 6'h00;
    else if (reg_wr && reg_addr == 8'h31) lvl_ff <= reg_wdata[5:0];
  end
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  fbz_value_a: assert property (!$past(sys_rst) |->
    fbz_threshold_cmg == 20'($past(front_back_z_threshold)) * 20'h187
    + 20'h2710) else $error("threshold value wrong");
  wm_clear_a: assert property (reg_wr && reg_addr == 8'h31 &&
    reg_wdata[5:0] != lvl_ff |=> fifo_frame_count == 6'h00)
    else $error("frame counter kept after level change");
  wm_irq_a: assert property (!$past(sys_rst) &&
    $past(frame_wr || frame_rd) |-> fifo_watermark_irq ==
    (fifo_frame_count > lvl_ff)) else $error("watermark flag wrong");
  st_on_a: assert property (cfg_wr |-> ##2
    selftest_ctl.selftest_on == $past(reg_wdata[7], 2))
    else $error("self-test enable wrong");
  st_amp_a: assert property (cfg_wr && reg_wdata[7] |-> ##2
    {selftest_ctl.amp_high, selftest_ctl.sign_pos} ==
    $past({reg_wdata[5], reg_wdata[2]}, 2)) else $error("amp or sign wrong");
  st_axis_a: assert property (cfg_wr && reg_wdata[7] |-> ##2
    selftest_ctl.axis == {$past(reg_wdata[1:0], 2) == AXIS_X,
    $past(reg_wdata[1:0], 2) == AXIS_Y, $past(reg_wdata[1], 2)})
    else $error("self-test axis wrong");
  step_mode_a: assert property (cfg_wr && !reg_wdata[7] &&
    reg_wdata[3] && step_enable ##1 step_enable ##1 step_enable |->
    {step_ctl.peak_valley_match, step_ctl.single_axis, step_ctl.axis} ==
    {$past(reg_wdata[5], 2), 1'b1, $past(reg_wdata[1:0], 2) == AXIS_X,
    $past(reg_wdata[1:0], 2) == AXIS_Y, $past(reg_wdata[1], 2)})
    else $error("step controls wrong");
  rsvd_zero_a: assert property (reg_rd && (reg_addr == 8'h31 ||
    reg_addr == 8'h34) |=> reg_rdata[7:6] == 2'h0)
    else $error("unused bits not zero");
  settle_wait_a: assert property ($rose(selftest_ctl.selftest_on) |->
    !selftest_settled [*8]) else $error("settled too early");
endmodule
bind sstcfg_regs sstcfg_regs_chk i_chk (.ref_clk, .sys_rst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
  .front_back_z_threshold, .fbz_threshold_cmg, .step_enable, .frame_wr,
  .frame_rd, .fifo_frame_count, .fifo_watermark_irq, .selftest_ctl,
  .step_ctl, .selftest_settled);

// >>> tb/sstcfg_regs_tb.sv
// Self-checking testbench for the configuration register bank.
`timescale 1ns/1ps
module sstcfg_regs_tb;
  import sstcfg_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic reg_wr, reg_rd, reg_rvalid, step_enable, frame_wr, frame_rd;
  logic fifo_watermark_irq, selftest_settled;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, front_back_z_threshold;
  logic [19:0] fbz_threshold_cmg;
  logic [5:0] fifo_frame_count;
  sstcfg_selftest_type selftest_ctl;
  sstcfg_step_type step_ctl;
  int err_count = 0;
  int checks = 0;
  sstcfg_regs i_dut (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .front_back_z_threshold,
    .fbz_threshold_cmg, .step_enable, .frame_wr, .frame_rd,
    .fifo_frame_count, .fifo_watermark_irq, .selftest_ctl, .step_ctl,
    .selftest_settled);
  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 20'h1, 20'(reg_rvalid));
    chk("reg_rdata", 20'(exp), 20'(reg_rdata));
  endtask
  task automatic frame(logic w);
    @(posedge ref_clk);
    frame_wr <= w;
    frame_rd <= !w;
    @(posedge ref_clk);
    {frame_wr, frame_rd} <= 2'h0;
    #1;
  endtask
  function automatic logic [2:0] ax(logic [1:0] a);
    return {a == AXIS_X, a == AXIS_Y, a[1]};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk("fbz_threshold_cmg", 20'h02710, fbz_threshold_cmg);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h34, 8'h00);
    wr(8'h31, 8'hff);
    wr(8'h32, 8'hff);
    wr(8'h33, 8'hff);
    wr(8'h34, 8'hff);
    rd(8'h31, 8'h3f);
    rd(8'h32, 8'hbf);
    rd(8'h33, 8'h00);
    rd(8'h34, 8'h3f);
    for (int c = 1; c < 256; c += 127) begin
      @(posedge ref_clk);
      front_back_z_threshold <= 8'(c);
      tick(1);
      chk("fbz", 20'(c) * 20'h187 + 20'h2710, fbz_threshold_cmg);
    end
    $display("register test done");
  endtask
  task automatic t_selftest;
    for (int a = 0; a < 4; a++) begin
      wr(8'h32, (a % 2) ? 8'ha4 | 8'(a) : 8'h80 | 8'(a));
      tick(1);
      chk("st", {14'h0, 1'b1, a[0], a[0], ax(2'(a))},
          20'(selftest_ctl));
    end
    // The host still owes the settling wait; the hint must stay low now.
    chk("selftest_settled", 20'h0, 20'(selftest_settled));
    wr(8'h32, 8'h00);
    tick(1);
    chk("selftest_ctl", 20'h0, 20'(selftest_ctl));
    $display("self-test test done");
  endtask
  task automatic t_step;
    @(posedge ref_clk);
    step_enable <= 1'b1;
    wr(8'h34, 8'hd5);
    for (int a = 0; a < 4; a++) begin
      wr(8'h32, (a % 2) ? 8'h28 | 8'(a) : 8'h08 | 8'(a));
      tick(1);
      chk("step", {9'h0, a[0], 1'b1, ax(2'(a)), 6'h15},
          20'(step_ctl));
    end
    @(posedge ref_clk);
    step_enable <= 1'b0;
    tick(2);
    chk("step_ctl", 20'h00015, 20'(step_ctl));
    $display("step test done");
  endtask
  task automatic t_fifo;
    wr(8'h31, 8'h02);
    for (int n = 1; n <= 3; n++) begin
      frame(1'b1);
      chk("fifo_frame_count", 20'(n), 20'(fifo_frame_count));
      chk("fifo_watermark_irq", 20'(n > 2), 20'(fifo_watermark_irq));
    end
    frame(1'b0);
    chk("fifo_watermark_irq", 20'h0, 20'(fifo_watermark_irq));
    frame(1'b1);
    wr(8'h31, 8'h01);
    tick(1);
    chk("fifo_frame_count", 20'h0, 20'(fifo_frame_count));
    chk("fifo_watermark_irq", 20'h0, 20'(fifo_watermark_irq));
    $display("watermark test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, step_enable, frame_wr, frame_rd} = 6'h20;
    {reg_addr, reg_wdata, front_back_z_threshold} = 24'h0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(1);
    t_regs();
    t_selftest();
    t_step();
    t_fifo();
    end_of_test();
  end
endmodule
